/* verilog/mnps_defs.vh */
`ifndef MNPS_DEFS_VH
`define MNPS_DEFS_VH
// register indices on the plain register port
`define MNPS_ADDR_W        4
`define MNPS_REG_CTRL      4'h0
`define MNPS_REG_RTIM      4'h1
`define MNPS_REG_WTIM      4'h2
`define MNPS_REG_STAT      4'h3
`define MNPS_REG_DATA      4'h4
`define MNPS_REG_HOSTREQ   4'h5
// reset values
`define MNPS_CTRL_RST      32'h000030d2
`define MNPS_TIM_RST       32'h0fffffff
// bank control field positions
`define MNPS_B_BANK_EN     0
`define MNPS_B_MUX_EN      1
`define MNPS_B_BURST_RD    8
`define MNPS_B_WAIT_POL    9
`define MNPS_B_WAIT_CFG    11
`define MNPS_B_WR_EN       12
`define MNPS_B_SYNC_WAIT   13
`define MNPS_B_EXT_MODE    14
`define MNPS_B_ASYNC_WAIT  15
`define MNPS_B_SYNC_WR     19
// timing register field positions
`define MNPS_T_ASET_LO     0
`define MNPS_T_AHLD_LO     4
`define MNPS_T_DATA_LO     8
`define MNPS_T_MDIV_LO     20
`define MNPS_T_LAT_LO      24
`define MNPS_T_MODE_LO     28
// access modes
`define MNPS_MODE_A        2'h0
`define MNPS_MODE_B        2'h1
`define MNPS_MODE_C        2'h2
`define MNPS_MODE_D        2'h3
// phase extensions in host clocks
`define MNPS_DATA_WR_EXTRA 8'h01
`define MNPS_DATA_RD_EXTRA 8'h03
`endif

/* verilog/mnps_memory_clock_divide.v */
`timescale 1ns/100ps
`include "mnps_defs.vh"
// memory clock divider: period of 2*((div>>1)+1) host clocks, rise/fall enables
module mnps_memory_clock_divide (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       run,      // divider active
  input  wire [3:0] div,      // clock-divide field
  output reg        mclk_r,   // memory clock level
  output wire       rise_en,  // one-cycle pulse before rising edge
  output wire       fall_en   // one-cycle pulse before falling edge
);
  reg  [3:0] cnt_r;           // host clocks within half period
  wire [3:0] half;            // half period length minus one
  wire       wrap;

  // zero is reserved; treat like one so the clock never stalls
  assign half    = (div == 4'h0) ? 4'h0 : (div >> 1);
  assign wrap    = run && (cnt_r >= half);
  assign rise_en = wrap && !mclk_r;
  assign fall_en = wrap && mclk_r;

  // count half periods, toggle clock on each wrap
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 4'h0;
      mclk_r <= 1'b0;
    end else if (!run) begin
      cnt_r  <= 4'h0;
      mclk_r <= 1'b0;
    end else if (wrap) begin
      cnt_r  <= 4'h0;
      mclk_r <= ~mclk_r;
    end else begin
      cnt_r  <= cnt_r + 4'h1;
    end
  end
endmodule

/* verilog/mnps_ctrl.v */
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "mnps_defs.vh"
// Summary of operation
// - access-mode field [31:28] stored but never decoded
// - data phase: field+1 write, +3 read
// - address hold lasts field plus one
// - read address setup from read timing
// - write address setup from write timing in extended mode, else read timing
// - wait polarity only used when enabled
// - latency excludes address-valid low clocks
// - 16-bit one burst, 32-bit two bursts
// - sample wait after latency plus one
// - wait keeps clock, selects; drops data
// - wait config picks wait/data alignment
// - clock-divide one is two host clocks
// - outputs on host edge; write data at fall
// - read/write may use different modes
// - memory strobes are active low
module mnps_ctrl (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg  [7:0]  mem_addr_hi,
  output reg  [15:0] mem_ad_out,
  output reg         mem_ad_oe,
  input  wire [15:0] mem_ad_in,
  output reg         chip_select_n,
  output reg         output_enable_n,
  output reg         write_strobe_n,
  output reg         address_valid_n,
  output reg  [1:0]  byte_lane_n,
  output wire        mem_clk,
  input  wire        memory_wait_n
);
  // states
  localparam S_IDLE = 3'h0;
  localparam S_ASET = 3'h1;
  localparam S_AHLD = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_SADR = 3'h4;
  localparam S_SLAT = 3'h5;
  localparam S_SXFR = 3'h6;
  localparam S_DONE = 3'h7;

  reg  [31:0] ctrl_r;         // bank_control
  reg  [31:0] rtim_r;         // bank_read_timing
  reg  [31:0] wtim_r;         // bank_write_timing
  reg  [31:0] wdat_r;         // host write data
  reg  [31:0] rdat_r;         // captured read data
  reg  [23:0] haddr_r;        // host halfword address
  reg         hwr_r;          // access is a write
  reg         h32_r;          // 32-bit host transfer
  reg         half_r;         // second halfword underway
  reg         busy_r;         // transfer running
  reg  [2:0]  st_r;
  reg  [7:0]  cnt_r;          // phase counter
  reg         wsync1_r;       // wait synchroniser
  reg         wsync2_r;
  reg  [15:0] ad_s1_r;        // shared-line read data, first stage
  reg  [15:0] ad_s2_r;        // second stage, the only one read
  reg  [31:0] tim;            // timing register in force
  wire        sync_mode;
  wire        wait_act;
  wire        rise_en;
  wire        fall_en;

  // pick the active register field
  function [3:0] nib;
    input [31:0] r;
    input integer lo;
    begin
      nib = r[lo +: 4];
    end
  endfunction

  // extended mode: reads use read timing, writes write timing
  always @* begin
    if (ctrl_r[`MNPS_B_EXT_MODE] && hwr_r)
      tim = wtim_r;
    else
      tim = rtim_r;
  end

  assign sync_mode = hwr_r ? ctrl_r[`MNPS_B_SYNC_WR]
                           : ctrl_r[`MNPS_B_BURST_RD];

  // wait pin crosses domains; async wait only when enabled
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wsync1_r <= 1'b1;
      wsync2_r <= 1'b1;
    end else begin
      wsync1_r <= memory_wait_n;
      wsync2_r <= wsync1_r;
    end
  end
  // read data from the pins passes two flops before capture; the
  // shortest read data phase still covers this two-clock lag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_s1_r <= 16'h0000;
      ad_s2_r <= 16'h0000;
    end else begin
      ad_s1_r <= mem_ad_in;
      ad_s2_r <= ad_s1_r;
    end
  end
  // polarity bit set means wait is active high
  assign wait_act = (wsync2_r == ctrl_r[`MNPS_B_WAIT_POL]);

  mnps_memory_clock_divide u_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     ((st_r == S_SADR) || (st_r == S_SLAT) || (st_r == S_SXFR)),
    .div     (nib(rtim_r, `MNPS_T_MDIV_LO)),
    .mclk_r  (mem_clk),
    .rise_en (rise_en),
    .fall_en (fall_en)
  );

  // register port and host request
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= `MNPS_CTRL_RST;
      rtim_r    <= `MNPS_TIM_RST;
      wtim_r    <= `MNPS_TIM_RST;
      wdat_r    <= 32'h00000000;
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_wr) begin
        case (reg_addr)
          `MNPS_REG_CTRL: ctrl_r <= reg_wdata;
          `MNPS_REG_RTIM: rtim_r <= reg_wdata;
          `MNPS_REG_WTIM: wtim_r <= reg_wdata;
          `MNPS_REG_DATA: wdat_r <= reg_wdata;
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `MNPS_REG_CTRL: reg_rdata <= ctrl_r;
          `MNPS_REG_RTIM: reg_rdata <= rtim_r;
          `MNPS_REG_WTIM: reg_rdata <= wtim_r;
          `MNPS_REG_STAT: reg_rdata <= {28'h0, st_r, busy_r};
          `MNPS_REG_DATA: reg_rdata <= rdat_r;
          default:        reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // access sequencer; all outputs registered on host clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r            <= S_IDLE;
      cnt_r           <= 8'h00;
      busy_r          <= 1'b0;
      hwr_r           <= 1'b0;
      h32_r           <= 1'b0;
      half_r          <= 1'b0;
      haddr_r         <= 24'h000000;
      rdat_r          <= 32'h00000000;
      mem_addr_hi     <= 8'h00;
      mem_ad_out      <= 16'h0000;
      mem_ad_oe       <= 1'b0;
      chip_select_n   <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n  <= 1'b1;
      address_valid_n <= 1'b1;
      byte_lane_n     <= 2'h3;
    end else begin
      case (st_r)
        S_IDLE: begin
          // hostreq write: [23:0] address, [24] write, [25] 32-bit
          if (reg_wr && reg_addr == `MNPS_REG_HOSTREQ &&
              ctrl_r[`MNPS_B_BANK_EN]) begin
            busy_r  <= 1'b1;
            haddr_r <= reg_wdata[23:0];
            hwr_r   <= reg_wdata[24];
            h32_r   <= reg_wdata[25];
            half_r  <= 1'b0;
            st_r    <= S_DONE;          // launch from DONE path
            cnt_r   <= 8'hff;
          end
        end
        S_ASET: begin
          // address on shared lines, latch strobe low
          if (cnt_r == 8'h00) begin
            address_valid_n <= 1'b1;
            st_r  <= S_AHLD;
            cnt_r <= {4'h0, nib(tim, `MNPS_T_AHLD_LO)};
          end else
            cnt_r <= cnt_r - 8'h01;
        end
        S_AHLD: begin
          if (cnt_r == 8'h00) begin
            st_r      <= S_DATA;
            mem_ad_oe <= hwr_r;
            mem_ad_out <= half_r ? wdat_r[31:16] : wdat_r[15:0];
            byte_lane_n <= 2'h0;
            if (hwr_r) begin
              write_strobe_n <= 1'b0;
              cnt_r <= tim[15:8] + `MNPS_DATA_WR_EXTRA - 8'h01;
            end else begin
              output_enable_n <= 1'b0;
              cnt_r <= tim[15:8] + `MNPS_DATA_RD_EXTRA - 8'h01;
            end
          end else
            cnt_r <= cnt_r - 8'h01;
        end
        S_DATA: begin
          // async wait freezes the data phase when enabled
          if (ctrl_r[`MNPS_B_ASYNC_WAIT] && wait_act) begin
            cnt_r <= cnt_r;
          end else if (cnt_r == 8'h00) begin
            if (!hwr_r) begin
              if (half_r) rdat_r[31:16] <= ad_s2_r;
              else        rdat_r[15:0]  <= ad_s2_r;
            end
            output_enable_n <= 1'b1;
            write_strobe_n  <= 1'b1;
            st_r <= S_DONE;
          end else
            cnt_r <= cnt_r - 8'h01;
        end
        S_SADR: begin
          // one clock of address valid low, not counted in latency
          if (rise_en) begin
            address_valid_n <= 1'b1;
            mem_ad_oe <= hwr_r;
            output_enable_n <= hwr_r;
            write_strobe_n  <= !hwr_r;
            byte_lane_n <= 2'h0;
            cnt_r <= {4'h0, nib(rtim_r, `MNPS_T_LAT_LO)} + 8'h01;
            st_r  <= S_SLAT;
          end
        end
        S_SLAT: begin
          // write data changes on the falling memory edge
          if (fall_en)
            mem_ad_out <= half_r ? wdat_r[31:16] : wdat_r[15:0];
          if (rise_en) begin
            if (cnt_r == 8'h00) st_r <= S_SXFR;
            else cnt_r <= cnt_r - 8'h01;
          end
        end
        S_SXFR: begin
          // wait config 1: wait leads data by one clock
          if (rise_en) begin
            if (ctrl_r[`MNPS_B_SYNC_WAIT] && wait_act) begin
              cnt_r <= {7'h0, ctrl_r[`MNPS_B_WAIT_CFG]};
            end else if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else begin
              if (!hwr_r) begin
                if (half_r) rdat_r[31:16] <= ad_s2_r;
                else        rdat_r[15:0]  <= ad_s2_r;
              end
              output_enable_n <= 1'b1;
              write_strobe_n  <= 1'b1;
              st_r <= S_DONE;
            end
          end
        end
        S_DONE: begin
          // end of one halfword; launch next or finish
          chip_select_n <= 1'b1;
          mem_ad_oe     <= 1'b0;
          byte_lane_n   <= 2'h3;
          if (cnt_r != 8'hff && (!h32_r || half_r)) begin
            busy_r <= 1'b0;
            st_r   <= S_IDLE;
          end else begin
            // 32-bit split into two halfword accesses
            half_r <= (cnt_r != 8'hff);
            chip_select_n   <= 1'b0;
            address_valid_n <= 1'b0;
            mem_ad_oe       <= 1'b1;
            mem_addr_hi     <= haddr_r[23:16];
            mem_ad_out      <= haddr_r[15:0] +
                               {15'h0, (cnt_r != 8'hff)};
            if (sync_mode)
              st_r <= S_SADR;
            else begin
              st_r  <= S_ASET;
              cnt_r <= {4'h0, nib(tim, `MNPS_T_ASET_LO)};
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule

/* bench/mnps_ctrl_props.sv */
`timescale 1ns/100ps
// port-level checks of the muxed nor/psram controller
module mnps_ctrl_props (
  input wire        clk,
  input wire        rst_n,
  input wire [3:0]  reg_addr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire [15:0] mem_ad_out,
  input wire        mem_ad_oe,
  input wire        chip_select_n,
  input wire        output_enable_n,
  input wire        write_strobe_n,
  input wire        address_valid_n,
  input wire        mem_clk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read data stands only in the answer cycle
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > 4'h5 |=> !reg_rdata)
    else $error("unmapped index read not zero");
  // address phase: select low and lines driven by the controller
  AST_ADV_IN_CS: assert property (
    !address_valid_n |-> !chip_select_n && mem_ad_oe)
    else $error("address valid without select or drive");
  AST_ADDR_STABLE: assert property (
    !address_valid_n && !$past(address_valid_n) |-> $stable(mem_ad_out))
    else $error("address moved while latch strobe low");
  AST_CS_ADV: assert property ($fell(chip_select_n) |-> !address_valid_n)
    else $error("access opened without address phase");
  AST_STROBE_EXCL: assert property (output_enable_n || write_strobe_n)
    else $error("read and write strobes low together");
  AST_WR_DRIVES: assert property (
    !write_strobe_n |-> !chip_select_n && mem_ad_oe)
    else $error("write strobe without drive or select");
  AST_RD_RELEASES: assert property (
    !output_enable_n |-> !mem_ad_oe && !chip_select_n)
    else $error("read strobe while lines driven");
  // shortest legal data phase is two host clocks on writes, four on reads
  AST_WR_MIN: assert property (
    $fell(write_strobe_n) |-> !write_strobe_n[*2])
    else $error("write data phase too short");
  AST_RD_MIN: assert property (
    $fell(output_enable_n) |-> !output_enable_n[*4])
    else $error("read data phase too short");
  AST_CLK_IDLE: assert property (
    chip_select_n && $past(chip_select_n) |-> !mem_clk)
    else $error("memory clock running while idle");
endmodule
bind mnps_ctrl mnps_ctrl_props i_mnps_ctrl_props (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mem_ad_out(mem_ad_out), .mem_ad_oe(mem_ad_oe),
  .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
  .write_strobe_n(write_strobe_n), .address_valid_n(address_valid_n),
  .mem_clk(mem_clk));

/* bench/mnps_mem_model.sv */
`timescale 1ns/100ps
// behavioural muxed memory: latches address, stores writes, drives reads
module mnps_mem_model (
  input  wire        clk,
  input  wire        cs_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        adv_n,
  input  wire [15:0] ad_out,
  input  wire        ad_oe,
  input  wire        stall,
  output wire [15:0] ad_in,
  output wire        wait_n
);
  reg [15:0] mem [0:15]; // word array, address wraps
  reg [3:0]  addr_r;     // latched word address
  reg [15:0] last_r;     // last bus level
  integer    i;
  initial begin
    addr_r = 4'h0;
    last_r = 16'h0;
    for (i = 0; i < 16; i = i + 1) mem[i] = 16'ha500 + i[15:0];
  end
  // address taken while latch strobe low, data while write strobe low
  always @(posedge clk) begin
    if (!cs_n && !adv_n) addr_r <= ad_out[3:0];
    if (!cs_n && !we_n && ad_oe) mem[addr_r] <= ad_out;
    last_r <= ad_in;
  end
  // undriven lines flip so a stale value never passes for data
  assign ad_in = ad_oe ? ad_out : (!cs_n && !oe_n) ? mem[addr_r] : ~last_r;
  assign wait_n = ~stall;
endmodule

/* bench/tb_mnps_ctrl.sv */
`timescale 1ns/100ps
`include "mnps_defs.vh"
// self-checking bench for the muxed nor/psram controller
module tb_mnps_ctrl;
  reg          clk, rst_n, reg_wr, reg_rd, stall;
  reg  [3:0]   reg_addr;
  reg  [31:0]  reg_wdata;
  wire [31:0]  reg_rdata;
  wire [7:0]   mem_addr_hi;
  wire [15:0]  mem_ad_out, mem_ad_in;
  wire [1:0]   byte_lane_n;
  wire         mem_ad_oe, chip_select_n, output_enable_n, write_strobe_n;
  wire         address_valid_n, mem_clk, memory_wait_n;
  int          err_total, samples_checked;
  int          n [6];    // running counters: strobe low cycles, clock rises, clock high
  int          d [6];    // counts over the last access
  reg          mclk_q;   // memory clock one cycle late
  int          base;     // burst clock rises with no wait
  logic [31:0] v;        // last register read
  mnps_ctrl i_mnps_ctrl (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_addr_hi(mem_addr_hi),
    .mem_ad_out(mem_ad_out), .mem_ad_oe(mem_ad_oe), .mem_ad_in(mem_ad_in),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .address_valid_n(address_valid_n),
    .byte_lane_n(byte_lane_n), .mem_clk(mem_clk),
    .memory_wait_n(memory_wait_n));
  mnps_mem_model i_mnps_mem_model (.clk(clk), .cs_n(chip_select_n),
    .oe_n(output_enable_n), .we_n(write_strobe_n), .adv_n(address_valid_n),
    .ad_out(mem_ad_out), .ad_oe(mem_ad_oe), .stall(stall),
    .ad_in(mem_ad_in), .wait_n(memory_wait_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // strobe widths and memory clock counted here, read as deltas around an access
  always @(posedge clk) begin
    mclk_q <= mem_clk;
    n[0] <= n[0] + !write_strobe_n;
    n[1] <= n[1] + !output_enable_n;
    n[2] <= n[2] + !address_valid_n;
    n[3] <= n[3] + !chip_select_n;
    n[4] <= n[4] + (mem_clk & !mclk_q);
    n[5] <= n[5] + mem_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input [3:0] a, input [31:0] dat);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input [3:0] a, output logic [31:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    q = reg_rdata;
  endtask
  // one host request, polled to idle under a bound
  task automatic go(input [31:0] req);
    int k;
    int s [6];
    s = n;
    wr(`MNPS_REG_HOSTREQ, req);
    for (k = 0; k < 100; k++) begin
      rd(`MNPS_REG_STAT, v);
      if (v[0] === 1'b0) break;
    end
    foreach (d[i]) d[i] = n[i] - s[i];
  endtask
  task automatic t_reset;
    rd(`MNPS_REG_CTRL, v);
    chk(v, `MNPS_CTRL_RST);
    rd(`MNPS_REG_RTIM, v);
    chk(v, `MNPS_TIM_RST);
    rd(`MNPS_REG_WTIM, v);
    chk(v, `MNPS_TIM_RST);
    rd(4'hf, v);
    chk(v, 32'h0);
  endtask
  // mode b writes against a mode c read with other timing
  task automatic t_async;
    int c;
    wr(`MNPS_REG_CTRL, 32'h000050cb);
    wr(`MNPS_REG_RTIM, 32'h20000425);
    wr(`MNPS_REG_WTIM, 32'h10000312);
    wr(`MNPS_REG_DATA, 32'h00001234);
    go(32'h01000003);
    chk(d[0], 4);
    chk(d[2], 3);
    c = d[3];
    wr(`MNPS_REG_WTIM, 32'h10000342);
    stall <= 1'b1;
    go(32'h01000003);
    stall <= 1'b0;
    chk(d[0], 4);
    chk(d[3] - c, 3);
    go(32'h00000003);
    chk(d[1], 7);
    chk(d[2], 6);
    rd(`MNPS_REG_DATA, v);
    chk(v & 32'hffff, 32'h1234);
  endtask
  // mode d, a wide read splits into two halfword accesses
  task automatic t_pair;
    wr(`MNPS_REG_RTIM, 32'h30000111);
    wr(`MNPS_REG_WTIM, 32'h30000111);
    go(32'h02000006);
    chk(d[1], 8);
    chk(d[2], 4);
    rd(`MNPS_REG_DATA, v);
    chk(v, 32'ha507a506);
  endtask
  // burst read, memory clock at two host clocks
  task automatic t_sync;
    wr(`MNPS_REG_CTRL, 32'h000001cb);
    wr(`MNPS_REG_RTIM, 32'h02100000);
    go(32'h00000009);
    chk(d[4] >= 3, 1);
    base = d[4];
    chk(d[5], d[4]);
    rd(`MNPS_REG_DATA, v);
    chk(v & 32'hffff, 32'ha509);
  endtask
  // wait held low: burst stalls with clock running, async phase freezes
  task automatic t_wait;
    wr(`MNPS_REG_CTRL, 32'h000021cb);
    stall <= 1'b1;
    fork
      go(32'h0000000b);
      begin
        repeat (30) @(posedge clk);
        stall <= 1'b0;
      end
    join
    chk(d[4] > base + 5, 1);
    chk(d[5], d[4]);
    rd(`MNPS_REG_DATA, v);
    chk(v & 32'hffff, 32'ha50b);
    wr(`MNPS_REG_CTRL, 32'h0000d0cb);
    stall <= 1'b1;
    fork
      go(32'h01000003);
      begin
        repeat (30) @(posedge clk);
        stall <= 1'b0;
      end
    join
    chk(d[0] > 7, 1);
  endtask
  // synchronous write, then burst read back through a high address
  task automatic t_swr;
    wr(`MNPS_REG_CTRL, 32'h00081087);
    wr(`MNPS_REG_DATA, 32'h00005aa5);
    go(32'h015a000a);
    chk(d[0] > 0, 1);
    chk(mem_addr_hi, 32'h5a);
    chk(byte_lane_n, 32'h3);
    wr(`MNPS_REG_CTRL, 32'h00081187);
    go(32'h005a000a);
    rd(`MNPS_REG_DATA, v);
    chk(v & 32'hffff, 32'h5aa5);
  endtask
  task automatic final_report;
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    stall = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_async;
    t_pair;
    t_sync;
    t_wait;
    t_swr;
    final_report;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    final_report;
  end
endmodule
